// File: rtl/i2cims_pkg.sv
// Purpose: constants and carriers for the event mask/status block
// Assumes: apb with 32-bit data, byte addresses
// Notes: offsets of mask, clear and index registers are local choices
`default_nettype none
package i2cims_pkg;
    localparam logic [12:0] OFF_MASK = 13'h1028;
    localparam logic [12:0] OFF_RAW = 13'h1030;
    localparam logic [12:0] OFF_MASKED = 13'h1038;
    localparam logic [12:0] OFF_CLEAR = 13'h1048;
    localparam logic [12:0] OFF_INDEX = 13'h1020;
    localparam logic [31:0] RAW_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] IMPL_BITS = 32'hffffffbf;
    localparam int BIT_CTL_RX_COMPLETE = 0;
    localparam int BIT_CTL_TX_COMPLETE = 1;
    localparam int BIT_CTL_RX_THRESHOLD = 2;
    localparam int BIT_CTL_TX_THRESHOLD = 3;
    localparam int BIT_CTL_RX_FULL = 4;
    localparam int BIT_CTL_TX_DRAINED = 5;
    localparam int BIT_CTL_NO_ACK = 7;
    localparam int BIT_TGT_BYTE_RECEIVED = 16;
    localparam int BIT_TGT_RX_FULL = 20;
    localparam int BIT_TGT_TX_DRAINED = 21;
    localparam int BIT_TGT_START_SEEN = 22;
    localparam int BIT_TGT_STOP_SEEN = 23;
    localparam int BIT_OVERFLOW = 31;
    localparam int FIFO_CNT_W = 5;
    typedef struct packed {
        logic [FIFO_CNT_W-1:0] ctl_tx_level;
        logic [FIFO_CNT_W-1:0] ctl_rx_level;
        logic [FIFO_CNT_W-1:0] ctl_tx_thresh;
        logic [FIFO_CNT_W-1:0] ctl_rx_thresh;
        logic [FIFO_CNT_W-1:0] tgt_rx_level;
        logic [FIFO_CNT_W-1:0] rx_depth;
        logic ctl_tx_idle;
        logic tgt_tx_idle;
        logic ctl_tx_level_zero;
        logic tgt_tx_level_zero;
    } i2cims_fifo_type;
endpackage
`default_nettype wire

// File: rtl/i2cims_top.sv
// Purpose: interrupt mask, raw status, masked status and index logic
// Assumes: single-cycle event pulses from the sources, apb master
// Notes: no wait states, pready is always high; read data is captured in the setup
// cycle and stands through the access phase
//
// How it works
// R01 - mask bit 1 lets a source through, 0 blocks it
// R02 - transmit drained flag sets when fifo empty and transmitter idle
// R03 - receive full flag sets when receive fifo becomes full
// R04 - controller tx threshold flag sets when level at or below threshold
// R05 - controller rx threshold flag sets when level at or above threshold
// R06 - target byte received flag sets per received byte
// R07 - raw status shows flags regardless of mask
// R08 - writing 1 to clear register clears flag, masked or not
// R09 - overflow flag sets on start or stop repeating while still pending
// R10 - target general call, dma done and error flags sit at bits 30 to 24
// R11 - shared and controller flags sit at bits 15 to 7
// R12 - target events at 23 to 16, controller done at 1 and 0
// R13 - raw status at 1030h, resets to zero, bit 6 reads zero
// R14 - masked status is mask and raw
// R15 - index read returns lowest pending source and clears it
// R16 - only unmasked flags reach index and masked status
// R17 - flags set by one-cycle pulses, held until cleared
`default_nettype none
module i2cims_top
    import i2cims_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [12:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [31:0] i_event_pulse,
    input wire i2cims_fifo_type i_fifo,
    output logic o_irq
);
    logic [31:0] event_enable_mask;
    logic [31:0] raw_event_status;
    logic [31:0] next_raw;
    logic [31:0] masked_event_status;
    logic [31:0] level_events;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] idx_clr;
    logic [31:0] rdata;
    logic [7:0] index_value;
    logic ctl_tx_thr;
    logic ctl_rx_thr;
    logic ctl_rx_full;
    logic tgt_rx_full;
    logic ctl_drain;
    logic tgt_drain;
    logic ctl_tx_thr_d;
    logic ctl_rx_thr_d;
    logic ctl_rx_full_d;
    logic tgt_rx_full_d;
    logic ctl_drain_d;
    logic tgt_drain_d;
    wire access = i_psel && i_penable;
    wire wr = access && i_pwrite;
    wire rd = access && !i_pwrite;
    wire hit_mask = i_paddr == OFF_MASK;
    wire hit_raw = i_paddr == OFF_RAW;
    wire hit_masked = i_paddr == OFF_MASKED;
    wire hit_clear = i_paddr == OFF_CLEAR;
    wire hit_index = i_paddr == OFF_INDEX;
    wire hit_any = hit_mask || hit_raw || hit_masked || hit_clear || hit_index;
    wire setup_rd = i_psel && !i_penable && !i_pwrite;
    wire wr_mask = wr && hit_mask;
    wire wr_clear = wr && hit_clear;
    wire rd_index = rd && hit_index;
    logic [31:0] pulse_bits;
    logic [31:0] rd_mask_word, rd_raw_word, rd_masked_word, rd_index_word;

    // one named wire per event source; bit 6 is reserved and has no source
    wire src_ctl_rx_complete = i_event_pulse[BIT_CTL_RX_COMPLETE]; // R12
    wire src_ctl_tx_complete = i_event_pulse[BIT_CTL_TX_COMPLETE]; // R12
    wire src_ctl_rx_threshold = i_event_pulse[BIT_CTL_RX_THRESHOLD]; // R05
    wire src_ctl_tx_threshold = i_event_pulse[BIT_CTL_TX_THRESHOLD]; // R04
    wire src_ctl_rx_full = i_event_pulse[BIT_CTL_RX_FULL]; // R03
    wire src_ctl_tx_drained = i_event_pulse[BIT_CTL_TX_DRAINED]; // R02
    wire src_ctl_no_acknowledge = i_event_pulse[BIT_CTL_NO_ACK]; // R11
    wire src_ctl_start_seen = i_event_pulse[8]; // R11
    wire src_ctl_stop_seen = i_event_pulse[9]; // R11
    wire src_ctl_arb_lost = i_event_pulse[10]; // R11
    wire src_ctl_dma_tx_done = i_event_pulse[11]; // R11
    wire src_ctl_dma_rx_done = i_event_pulse[12]; // R11
    wire src_ctl_pec_error = i_event_pulse[13]; // R11
    wire src_timeout_first = i_event_pulse[14]; // R11
    wire src_timeout_second = i_event_pulse[15]; // R11
    wire src_tgt_byte_received = i_event_pulse[BIT_TGT_BYTE_RECEIVED]; // R06 R12
    wire src_tgt_tx_complete = i_event_pulse[17]; // R12
    wire src_tgt_rx_threshold = i_event_pulse[18]; // R12
    wire src_tgt_tx_threshold = i_event_pulse[19]; // R12
    wire src_tgt_rx_full = i_event_pulse[BIT_TGT_RX_FULL]; // R03
    wire src_tgt_tx_drained = i_event_pulse[BIT_TGT_TX_DRAINED]; // R02
    wire src_tgt_start_seen = i_event_pulse[BIT_TGT_START_SEEN]; // R12
    wire src_tgt_stop_seen = i_event_pulse[BIT_TGT_STOP_SEEN]; // R09
    wire src_tgt_general_call = i_event_pulse[24]; // R10
    wire src_tgt_dma_tx_done = i_event_pulse[25]; // R10
    wire src_tgt_dma_rx_done = i_event_pulse[26]; // R10
    wire src_tgt_pec_error = i_event_pulse[27]; // R10
    wire src_tgt_tx_underflow = i_event_pulse[28]; // R10
    wire src_tgt_rx_overflow = i_event_pulse[29]; // R10
    wire src_tgt_arb_lost = i_event_pulse[30]; // R10
    wire src_event_overflow_flag = i_event_pulse[BIT_OVERFLOW]; // R09

    // lowest set bit wins; index is bit position plus one, zero when idle
    function automatic logic [7:0] pick_index(input logic [31:0] v);
        logic [7:0] r;
        // scanned from the top, so the lowest pending bit is written last and wins
        r = 8'h00;
        if (v[31]) r = 8'h20;
        if (v[30]) r = 8'h1f;
        if (v[29]) r = 8'h1e;
        if (v[28]) r = 8'h1d;
        if (v[27]) r = 8'h1c;
        if (v[26]) r = 8'h1b;
        if (v[25]) r = 8'h1a;
        if (v[24]) r = 8'h19;
        if (v[23]) r = 8'h18;
        if (v[22]) r = 8'h17;
        if (v[21]) r = 8'h16;
        if (v[20]) r = 8'h15;
        if (v[19]) r = 8'h14;
        if (v[18]) r = 8'h13;
        if (v[17]) r = 8'h12;
        if (v[16]) r = 8'h11;
        if (v[15]) r = 8'h10;
        if (v[14]) r = 8'h0f;
        if (v[13]) r = 8'h0e;
        if (v[12]) r = 8'h0d;
        if (v[11]) r = 8'h0c;
        if (v[10]) r = 8'h0b;
        if (v[9]) r = 8'h0a;
        if (v[8]) r = 8'h09;
        if (v[7]) r = 8'h08;
        if (v[5]) r = 8'h06;
        if (v[4]) r = 8'h05;
        if (v[3]) r = 8'h04;
        if (v[2]) r = 8'h03;
        if (v[1]) r = 8'h02;
        if (v[0]) r = 8'h01;
        return r;
    endfunction

    function automatic logic [31:0] one_hot(input logic [7:0] idx);
        logic [31:0] r;
        r = 32'h00000000;
        // codes that name no source clear nothing
        case (idx)
            8'h01: r = 32'h00000001;
            8'h02: r = 32'h00000002;
            8'h03: r = 32'h00000004;
            8'h04: r = 32'h00000008;
            8'h05: r = 32'h00000010;
            8'h06: r = 32'h00000020;
            8'h08: r = 32'h00000080;
            8'h09: r = 32'h00000100;
            8'h0a: r = 32'h00000200;
            8'h0b: r = 32'h00000400;
            8'h0c: r = 32'h00000800;
            8'h0d: r = 32'h00001000;
            8'h0e: r = 32'h00002000;
            8'h0f: r = 32'h00004000;
            8'h10: r = 32'h00008000;
            8'h11: r = 32'h00010000;
            8'h12: r = 32'h00020000;
            8'h13: r = 32'h00040000;
            8'h14: r = 32'h00080000;
            8'h15: r = 32'h00100000;
            8'h16: r = 32'h00200000;
            8'h17: r = 32'h00400000;
            8'h18: r = 32'h00800000;
            8'h19: r = 32'h01000000;
            8'h1a: r = 32'h02000000;
            8'h1b: r = 32'h04000000;
            8'h1c: r = 32'h08000000;
            8'h1d: r = 32'h10000000;
            8'h1e: r = 32'h20000000;
            8'h1f: r = 32'h40000000;
            8'h20: r = 32'h80000000;
            default: r = 32'h00000000;
        endcase
        return r;
    endfunction

    // level conditions are turned into single pulses on their rising edge
    // detectors reset low, so a level already true at release fires once
    assign ctl_tx_thr = i_fifo.ctl_tx_level <= i_fifo.ctl_tx_thresh; // R04
    assign ctl_rx_thr = i_fifo.ctl_rx_level >= i_fifo.ctl_rx_thresh; // R05
    assign ctl_rx_full = i_fifo.ctl_rx_level == i_fifo.rx_depth; // R03
    assign tgt_rx_full = i_fifo.tgt_rx_level == i_fifo.rx_depth; // R03
    assign ctl_drain = i_fifo.ctl_tx_level_zero && i_fifo.ctl_tx_idle; // R02
    assign tgt_drain = i_fifo.tgt_tx_level_zero && i_fifo.tgt_tx_idle; // R02

    always_comb begin
        level_events = 32'h00000000;
        level_events[BIT_CTL_TX_THRESHOLD] = ctl_tx_thr && !ctl_tx_thr_d; // R04
        level_events[BIT_CTL_RX_THRESHOLD] = ctl_rx_thr && !ctl_rx_thr_d; // R05
        level_events[BIT_CTL_RX_FULL] = ctl_rx_full && !ctl_rx_full_d; // R03
        level_events[BIT_TGT_RX_FULL] = tgt_rx_full && !tgt_rx_full_d; // R03
        level_events[BIT_CTL_TX_DRAINED] = ctl_drain && !ctl_drain_d; // R02
        level_events[BIT_TGT_TX_DRAINED] = tgt_drain && !tgt_drain_d; // R02
    end

    // overflow: start or stop pulse while its flag still stands
    wire ovf = (src_tgt_start_seen && raw_event_status[BIT_TGT_START_SEEN])
            || (src_tgt_stop_seen && raw_event_status[BIT_TGT_STOP_SEEN]); // R09

    // bit layout is fixed by the position of each source pulse
    assign pulse_bits = {
        src_event_overflow_flag,
        src_tgt_arb_lost,
        src_tgt_rx_overflow,
        src_tgt_tx_underflow,
        src_tgt_pec_error,
        src_tgt_dma_rx_done,
        src_tgt_dma_tx_done,
        src_tgt_general_call,
        src_tgt_stop_seen,
        src_tgt_start_seen,
        src_tgt_tx_drained,
        src_tgt_rx_full,
        src_tgt_tx_threshold,
        src_tgt_rx_threshold,
        src_tgt_tx_complete,
        src_tgt_byte_received,
        src_timeout_second,
        src_timeout_first,
        src_ctl_pec_error,
        src_ctl_dma_rx_done,
        src_ctl_dma_tx_done,
        src_ctl_arb_lost,
        src_ctl_stop_seen,
        src_ctl_start_seen,
        src_ctl_no_acknowledge,
        1'b0,
        src_ctl_tx_drained,
        src_ctl_rx_full,
        src_ctl_tx_threshold,
        src_ctl_rx_threshold,
        src_ctl_tx_complete,
        src_ctl_rx_complete
    }; // R10 R11 R12 R06
    assign set_bits = ((pulse_bits | level_events) & IMPL_BITS)
                    | (ovf ? (32'h00000001 << BIT_OVERFLOW) : 32'h00000000); // R17 R09
    // only unmasked flags reach the index and the interrupt line
    assign masked_event_status = raw_event_status & event_enable_mask; // R14 R16 R01
    assign index_value = pick_index(masked_event_status); // R15 R16
    // the clear follows the code already latched for the bus, so a pulse that
    // lands during the access cannot make the word read and the bit cleared differ
    assign idx_clr = rd_index ? one_hot(o_prdata[7:0]) : 32'h00000000; // R15
    assign clr_bits = (wr_clear ? i_pwdata : 32'h00000000) | idx_clr; // R08
    // set beats clear in the same cycle so no event is lost
    assign next_raw = ((raw_event_status & ~clr_bits) | set_bits) & IMPL_BITS; // R07 R08 R13
    assign o_irq = |masked_event_status; // R01

    // unmapped addresses read as zero and raise pslverr
    assign rd_mask_word = hit_mask ? event_enable_mask : 32'h00000000;
    assign rd_raw_word = hit_raw ? raw_event_status : 32'h00000000; // R07 R13
    assign rd_masked_word = hit_masked ? masked_event_status : 32'h00000000; // R14
    assign rd_index_word = hit_index ? {24'h000000, index_value} : 32'h00000000; // R15
    assign rdata = rd_mask_word | rd_raw_word | rd_masked_word | rd_index_word;
    // every register answers at once, so no wait state is ever inserted
    assign o_pready = 1'b1;
    assign o_pslverr = access && !hit_any;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            raw_event_status <= RAW_RESET; // R13
            event_enable_mask <= MASK_RESET;
            o_prdata <= 32'h00000000;
        end else begin
            raw_event_status <= next_raw;
            if (wr_mask) begin
                event_enable_mask <= i_pwdata & IMPL_BITS; // R01
            end
            // loaded in the setup cycle so the word stands for the whole access phase
            if (setup_rd) begin
                o_prdata <= rdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_tx_thr_d <= 1'b0;
            ctl_rx_thr_d <= 1'b0;
            ctl_rx_full_d <= 1'b0;
            tgt_rx_full_d <= 1'b0;
            ctl_drain_d <= 1'b0;
            tgt_drain_d <= 1'b0;
        end else begin
            ctl_tx_thr_d <= ctl_tx_thr;
            ctl_rx_thr_d <= ctl_rx_thr;
            ctl_rx_full_d <= ctl_rx_full;
            tgt_rx_full_d <= tgt_rx_full;
            ctl_drain_d <= ctl_drain;
            tgt_drain_d <= tgt_drain;
        end
    end
endmodule
`default_nettype wire

// File: verif/i2cims_checker.sv
// Purpose: port checks for the event mask and status block
// Assumes: zero-wait apb. Notes: flag state is judged by its effects only
`default_nettype none
module i2cims_checker import i2cims_pkg::*; (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [12:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire acc = i_psel && i_penable;
    wire rdacc = acc && !i_pwrite;
    wire hit = i_paddr inside {OFF_MASK, OFF_RAW, OFF_MASKED, OFF_CLEAR, OFF_INDEX};
    a_ready_high: assert property (o_pready) else $error("pready low");
    a_unmapped_err: assert property (acc && !hit |-> o_pslverr) else $error("no error");
    a_mapped_ok: assert property (acc && hit |-> !o_pslverr) else $error("false error");
    a_unmapped_zero: assert property (rdacc && !hit |-> o_prdata == '0) else $error("nonzero");
    a_raw_bit_six: assert property (rdacc && i_paddr == OFF_RAW |-> !o_prdata[6])
        else $error("bit 6 set");
    a_read_hold: assert property (!$stable(o_prdata) |-> $past(i_psel && !i_penable && !i_pwrite))
        else $error("data moved");
    a_reset_quiet: assert property ($rose(i_resetn) |-> o_prdata == '0 && !o_irq)
        else $error("not quiet");
    a_irq_hold: assert property ($fell(o_irq) |-> $past(acc && hit)) else $error("irq lost");
    cover property (o_irq);
    cover property (acc && o_pslverr);
    cover property ($fell(o_irq));
endmodule
bind i2cims_top i2cims_checker chk (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_irq);
`default_nettype wire

// File: verif/i2cims_top_tb.sv
// Purpose: self-checking bench for the event mask and status block
// Assumes: read data stands in the access phase. Notes: fifo levels start off every threshold
`default_nettype none
module i2cims_top_tb import i2cims_pkg::*; ();
    timeunit 1ns / 1ps;
    logic i_clk = 1'b0, i_resetn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, irq;
    logic [12:0] addr = 13'h0000;
    logic [31:0] wdata = 32'h0, pulse = 32'h0, prdata, m = 32'h008000c1;
    logic [31:0] row_p [4] = '{32'h1, 32'h40, 32'h800000, 32'h80000000};
    logic [31:0] row_r [4] = '{32'h1, 32'h1, 32'h800001, 32'h80800001};
    i2cims_fifo_type fifo = {5'h03, 5'h0f, 5'h02, 5'h10, 5'h0f, 5'h10, 4'h0};
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cyc == 1000) finish_test(1);
    i2cims_top dut (.i_clk, .i_resetn, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata), .o_pready(rdy),
        .o_pslverr(err), .i_event_pulse(pulse), .i_fifo(fifo), .o_irq(irq));
    task automatic finish_test(input int extra);
        n_mismatch += extra;
        $display("mismatch %0d compare %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] v, p = 32'h0);
        logic [31:0] got;
        logic bad_err;
        pulse <= p;
        @(posedge i_clk);
        {psel, pwr, addr, wdata, pulse} <= {1'b1, w, a, v, 32'h0};
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        while (rdy !== 1'b1) @(posedge i_clk);
        got = prdata;
        bad_err = err !== !(a inside {OFF_MASK, OFF_RAW, OFF_MASKED, OFF_CLEAR, OFF_INDEX});
        {psel, pen} <= 2'b00;
        cmp_count += 1 + int'(!w);
        n_mismatch += int'(bad_err) + int'(!w && got !== v);
        if (bad_err) $display("BAD %0t got %h exp %h", $time, err, !err);
        if (!w && got !== v) $display("BAD %0t got %h exp %h", $time, got, v);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b0, OFF_RAW, RAW_RESET);
        apb(1'b0, 13'h1000, 32'h0);
        apb(1'b1, OFF_MASK, m);
        apb(1'b0, OFF_MASK, 32'h00800081);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, OFF_RAW, row_r[i], row_p[i]);
            apb(1'b0, OFF_MASKED, row_r[i] & m);
        end
        cmp_count += 1;
        n_mismatch += int'(irq !== 1'b1);
        if (irq !== 1'b1) $display("BAD %0t got %h exp %h", $time, irq, 1'b1);
        apb(1'b1, OFF_CLEAR, 32'hffffffff);
        apb(1'b0, OFF_RAW, 32'h400000, 32'h400000);
        apb(1'b0, OFF_RAW, 32'h80400000, 32'h400000);
        apb(1'b0, OFF_RAW, 32'h80410081, 32'h10081);
        apb(1'b0, OFF_INDEX, 32'h1);
        apb(1'b0, OFF_INDEX, 32'h8);
        @(posedge i_clk) fifo <= {5'h02, 5'h10, 5'h02, 5'h10, 5'h10, 5'h10, 4'hf};
        apb(1'b0, OFF_INDEX, 32'h0);
        apb(1'b0, OFF_RAW, 32'h8071003c);
        cmp_count += 1;
        n_mismatch += int'(irq !== 1'b0);
        if (irq !== 1'b0) $display("BAD %0t got %h exp %h", $time, irq, 1'b0);
        fifo <= {5'h03, 5'h0f, 5'h02, 5'h10, 5'h0f, 5'h10, 4'h0};
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b0, OFF_RAW, RAW_RESET);
        apb(1'b0, OFF_MASK, MASK_RESET);
        finish_test(0);
    end
endmodule
`default_nettype wire
